// file: test/counter_array_module_config_tb.sv
`timescale 1ns/1ps
module counter_array_module_config_tb;
  import ca_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic tick, idle, oovf, oovf_ie, t0, ext;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [5:0] far_level, pin_in, pin_out, pin_oe_n;
  int mismatches, n_compared;
  localparam logic [7:0] CAP_MODES [3] = '{8'hA0, 8'h10, 8'hB0};

  counter_array_top counter_array_top_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .prescaler_tick(tick),
    .timer0_overflow(t0), .ext_clock(ext), .idle_mode(idle),
    .other_overflow(oovf), .other_overflow_irq_enable(oovf_ie),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe_n(pin_oe_n), .irq(irq)
  );
  pin_model pin_model_inst (
    .far_level(far_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in)
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ****************************************
  // Bus and comparison helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic edge_wait(inout int n);
    @(posedge hclk);
    n++;
    if (n > 2000)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // The master holds each phase until it samples hready high.
  task automatic bus(input logic w, input logic [9:0] i,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, i, 2'b00};
    hwrite <= w;
    edge_wait(n);
    while (hreadyout !== 1'b1)
      edge_wait(n);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    edge_wait(n);
    while (hreadyout !== 1'b1)
      edge_wait(n);
    q = hrdata[7:0];
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [9:0] i, output logic [7:0] q);
    bus(1'b0, i, 8'h00, q);
  endtask

  task automatic rdc(input logic [9:0] i, input logic [7:0] e);
    logic [7:0] q;
    rd(i, q);
    check(q, e);
  endtask

  task automatic poll(input logic [9:0] i, input int b);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while (q[b] !== 1'b1)
    begin
      rd(i, q);
      n++;
      if (n > 800)
      begin
        mismatches++;
        tally_and_finish();
      end
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdc(IDX_STATUS, STA_RESET);
    rdc(IDX_CONTROL, CTL_RESET);
    for (int n = 0; n < NUM_CH; n++)
      rdc(IDX_MODE0 + 10'(n), MODE_RESET);
    check(pin_oe_n, 8'h3F);
    rdc(10'h3FF, 8'h00);
    check(hresp, 1'b0);
    wr(IDX_CONTROL, 8'hFF);
    rdc(IDX_CONTROL, CTL_WMASK);
    wr(IDX_CONTROL, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_counter();
    logic [7:0] a, b;
    wr(IDX_CONTROL, 8'h44);
    poll(IDX_STATUS, STA_OVF);
    check(irq, 1'b0);
    rdc(IDX_CONTROL, 8'h44);
    wr(IDX_CONTROL, 8'h64);
    repeat (2) @(posedge hclk);
    check(irq, 1'b1);
    idle <= 1'b1;
    wr(IDX_CONTROL, 8'h74);
    rd(IDX_CNT_LO, a);
    rd(IDX_CNT_LO, b);
    check(b, a);
    wr(IDX_CONTROL, 8'h64);
    rd(IDX_CNT_LO, a);
    rd(IDX_CNT_LO, b);
    check(b, a + 8'h03);
    wr(IDX_CONTROL, 8'h67);
    rd(IDX_CNT_LO, a);
    rd(IDX_CNT_LO, b);
    check(b, a);
    idle <= 1'b0;
    wr(IDX_CONTROL, 8'h20);
    wr(IDX_STATUS, 8'h80);
    rdc(IDX_STATUS, 8'h00);
    check(irq, 1'b0);
    oovf_ie <= 1'b1;
    oovf <= 1'b1;
    @(posedge hclk);
    oovf <= 1'b0;
    repeat (3) @(posedge hclk);
    check(irq, 1'b1);
    rdc(IDX_STATUS, 8'h40);
    wr(IDX_STATUS, 8'h40);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    oovf_ie <= 1'b0;
    wr(IDX_CONTROL, 8'h00);
    $display("test counter done");
  endtask

  // The counter is stopped, so every capture must hold its value.
  task automatic t_capture();
    logic [7:0] lo, hi, q;
    rd(IDX_CNT_LO, lo);
    rd(IDX_CNT_HI, hi);
    for (int n = 0; n < 3; n++)
    begin
      wr(IDX_MODE0 + 10'(n), CAP_MODES[n]);
      far_level[n] <= 1'b1;
      repeat (4) @(posedge hclk);
      rd(IDX_STATUS, q);
      check(q[n], CAP_MODES[n][MODE_CAPR]);
      wr(IDX_STATUS, 8'h3F);
      far_level[n] <= 1'b0;
      repeat (4) @(posedge hclk);
      rd(IDX_STATUS, q);
      check(q[n], CAP_MODES[n][MODE_CAPF]);
      check(irq, q[n] & CAP_MODES[n][MODE_IE]);
      rdc(IDX_CMPL0 + 10'(n), lo);
      rdc(IDX_CMPH0 + 10'(n), hi);
      wr(IDX_STATUS, 8'h3F);
      wr(IDX_MODE0 + 10'(n), 8'h00);
    end
    $display("test capture done");
  endtask

  task automatic t_toggle();
    logic [7:0] q;
    logic p;
    wr(IDX_MODE0 + 10'd3, 8'h4C);
    wr(IDX_CMPL0 + 10'd3, 8'h10);
    rdc(IDX_MODE0 + 10'd3, 8'h0C);
    wr(IDX_CONTROL, 8'h44);
    repeat (1100) @(posedge hclk);
    rd(IDX_STATUS, q);
    check(q[3], 1'b0);
    check(pin_oe_n[3], 1'b0);
    p = pin_out[3];
    wr(IDX_CMPH0 + 10'd3, 8'h00);
    rdc(IDX_MODE0 + 10'd3, 8'h4C);
    poll(IDX_STATUS, 3);
    wr(IDX_CONTROL, 8'h00);
    check(pin_out[3], !p);
    check(irq, 1'b0);
    wr(IDX_STATUS, 8'hFF);
    wr(IDX_MODE0 + 10'd3, 8'h00);
    $display("test toggle done");
  endtask

  task automatic t_pwm();
    for (int c = 1; c < 4; c++)
    begin
      wr(IDX_MODE0 + 10'd4, {6'h10, 2'(c)});
      wr(IDX_CMPL0 + 10'd4, 8'h00);
      repeat (2) @(posedge hclk);
      check(pin_out[4], 1'b0);
      wr(IDX_CMPH0 + 10'd4, 8'h00);
      repeat (2) @(posedge hclk);
      check(pin_oe_n[4], 1'b0);
      check(pin_out[4], 1'b1);
    end
    wr(IDX_MODE0 + 10'd4, 8'h00);
    repeat (2) @(posedge hclk);
    check(pin_oe_n[4], 1'b1);
    $display("test pwm done");
  endtask

  // A level held on the external source must count once, on its edge.
  task automatic t_source();
    logic [7:0] a, b;
    wr(IDX_CONTROL, 8'h41);
    rd(IDX_CNT_LO, a);
    repeat (3) @(posedge hclk);
    rd(IDX_CNT_LO, b);
    check(b, a);
    t0 <= 1'b1;
    @(posedge hclk);
    t0 <= 1'b0;
    rd(IDX_CNT_LO, b);
    check(b, a + 8'h01);
    wr(IDX_CONTROL, 8'h42);
    ext <= 1'b1;
    repeat (3) @(posedge hclk);
    ext <= 1'b0;
    rd(IDX_CNT_LO, a);
    check(a, b + 8'h01);
    wr(IDX_CONTROL, 8'h00);
    $display("test source done");
  endtask

  initial
  begin
    mismatches = 0;
    n_compared = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    tick = 1'b1;
    t0 = 1'b0;
    ext = 1'b0;
    idle = 1'b0;
    oovf = 1'b0;
    oovf_ie = 1'b0;
    far_level = 6'h00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_counter();
    t_capture();
    t_toggle();
    t_pwm();
    t_source();
    tally_and_finish();
  end
endmodule

// file: test/pin_model.sv
`timescale 1ns/1ps
module pin_model (
  // Levels that the far side puts on the pins.
  input wire logic [5:0] far_level,
  // Design side of the pins.
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  output logic [5:0] pin_in
);
  // A pin that the design drives shows the design's level; the far side
  // only sets the level where the design has let go of the pin.
  assign pin_in = (pin_out & ~pin_oe_n) | (far_level & pin_oe_n);
endmodule

// file: verilog/ca_pkg.sv
package ca_pkg;

  // ********************************************************************
  // Register indices; the byte address is four times the index.
  // ********************************************************************
  localparam int NUM_CH = 6;
  localparam logic [9:0] IDX_STATUS = 10'h0A5;
  localparam logic [9:0] IDX_CONTROL = 10'h0BC;
  localparam logic [9:0] IDX_MODE0 = 10'h0C0;
  localparam logic [9:0] IDX_CMPL0 = 10'h0D0;
  localparam logic [9:0] IDX_CMPH0 = 10'h0D8;
  localparam logic [9:0] IDX_CNT_LO = 10'h0E0;
  localparam logic [9:0] IDX_CNT_HI = 10'h0E1;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int CTL_RUN = 6;
  localparam int CTL_OVF_IE = 5;
  localparam int CTL_IDLE = 4;
  localparam int CTL_TEN = 2;
  localparam int MODE_IE = 7;
  localparam int MODE_COMP = 6;
  localparam int MODE_CAPR = 5;
  localparam int MODE_CAPF = 4;
  localparam int MODE_MATCH = 3;
  localparam int MODE_TOGGLE = 2;
  localparam int STA_OTHER_OVF = 6;
  localparam int STA_OVF = 7;

  // ********************************************************************
  // Reset values, masks and codes.
  // ********************************************************************
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'h77;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STA_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX16 = 16'hFFFF;
  localparam logic [15:0] CNT_MAX10 = 16'h03FF;
  localparam logic [1:0] CLK_PRESCALE = 2'b00;
  localparam logic [1:0] CLK_TIMER0 = 2'b01;
  localparam logic [1:0] CLK_EXT = 2'b10;
  localparam logic [1:0] PWM_OFF = 2'b00;
  localparam logic [1:0] PWM_8_FIXED = 2'b01;
  localparam logic [1:0] PWM_8_PROG = 2'b10;
  localparam logic [1:0] PWM_WIDE = 2'b11;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_RDWAIT = 2'b10,
    BUS_RDDATA = 2'b11
  } bus_state_e;

endpackage

// file: verilog/counter_array_top.sv
// Functional notes
// - Run bit starts the counter; only software clears it.
// - Overflow flag raises the interrupt only while overflow enable is set.
// - With idle stop set the counter halts during processor idle.
// - Wide pulse width bit picks 10-bit (one) or 16-bit (zero).
// - Clock select: prescaler, timer 0 overflow, or external pin rising edges.
// - Six channel and two overflow sources are ORed into one request.
// - Mode bit 7 gates the channel flag onto the interrupt request.
// - Mode bit 6 enables the comparator; off means no compare action.
// - Mode bit 5 captures the counter on a rising pin edge.
// - Mode bit 4 captures the counter on a falling pin edge.
// - Both capture bits capture on every pin transition.
// - Mode bit 3 makes a comparator match set the channel flag.
// - Mode bit 2 makes each match invert the channel pin while the PWM field is zero.
// - Two-bit field selects 8-bit fixed, 8-bit programmable or wide PWM.
// - Every channel mode register resets to zero, meaning no operation.
// - Compare low byte write clears comparator enable, high byte sets it.
`timescale 1ns/1ps
module counter_array_top (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Counter clock sources and processor state.
  input wire logic prescaler_tick,
  input wire logic timer0_overflow,
  input wire logic ext_clock,
  input wire logic idle_mode,
  // Overflow of the other counter array.
  input wire logic other_overflow,
  input wire logic other_overflow_irq_enable,
  // Channel pins.
  input wire logic [ca_pkg::NUM_CH-1:0] channel_pin_in,
  output logic [ca_pkg::NUM_CH-1:0] channel_pin_out,
  output logic [ca_pkg::NUM_CH-1:0] channel_pin_oe_n,
  // Combined interrupt request.
  output logic irq
);
  import ca_pkg::*;

  // ********************************************************************
  // Register decode.
  // ********************************************************************
  // The top bit of the stored index flags an address above the map, so
  // such an access never matches any register.
  function automatic logic is_reg(input logic [10:0] a,
                                  input logic [9:0] idx);
    is_reg = (a == {1'b0, idx});
  endfunction

  bus_state_e bus_state_reg, bus_state_next;
  logic [10:0] addr_reg, addr_next;
  logic [31:0] hrdata_next;
  logic hreadyout_next;
  logic take, wr_en;
  logic [7:0] wdata;
  logic [7:0] read_byte;

  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] status_reg, status_next;
  logic [7:0] mode_reg [NUM_CH];
  logic [7:0] mode_next [NUM_CH];
  logic [15:0] cnt_reg, cnt_next;
  logic step_reg, step_next;
  logic ext_prev_reg, ext_prev_next;
  logic irq_next;
  logic tick, run, wrap;
  logic [15:0] wrap_max;

  logic [NUM_CH-1:0] wr_low, wr_high, wr_mode, chan_event, chan_ie;
  logic [15:0] cmp [NUM_CH];

  assign take = hsel && htrans[1] && hready;
  assign wr_en = (bus_state_reg == BUS_WRITE);
  assign wdata = hwdata[7:0];

  // ********************************************************************
  // Bus slave.
  // ********************************************************************
  // Writes finish with no wait state. A read inserts one wait so that the
  // word latched into hrdata already holds any write of the cycle before.
  always_comb
  begin
    addr_next = addr_reg;
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_RDWAIT:
        bus_state_next = BUS_RDDATA;
      default:
      begin
        if (take)
        begin
          addr_next = {|haddr[31:12], haddr[11:2]};
          bus_state_next = hwrite ? BUS_WRITE : BUS_RDWAIT;
        end
        else
        begin
          bus_state_next = BUS_IDLE;
        end
      end
    endcase
    hreadyout_next = (bus_state_next != BUS_RDWAIT);
    read_byte = 8'h00;
    if (is_reg(addr_reg, IDX_STATUS))
    begin
      read_byte = status_reg;
    end
    else if (is_reg(addr_reg, IDX_CONTROL))
    begin
      read_byte = ctl_reg;
    end
    else if (is_reg(addr_reg, IDX_CNT_LO))
    begin
      read_byte = cnt_reg[7:0];
    end
    else if (is_reg(addr_reg, IDX_CNT_HI))
    begin
      read_byte = cnt_reg[15:8];
    end
    else
    begin
      for (int n = 0; n < NUM_CH; n++)
      begin
        if (is_reg(addr_reg, IDX_MODE0 + 10'(n)))
        begin
          read_byte = mode_reg[n];
        end
        else if (is_reg(addr_reg, IDX_CMPL0 + 10'(n)))
        begin
          read_byte = cmp[n][7:0];
        end
        else if (is_reg(addr_reg, IDX_CMPH0 + 10'(n)))
        begin
          read_byte = cmp[n][15:8];
        end
      end
    end
    hrdata_next = hrdata;
    if (bus_state_reg == BUS_RDWAIT)
    begin
      hrdata_next = {24'h000000, read_byte};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state_reg <= BUS_IDLE;
      addr_reg <= 11'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      bus_state_reg <= bus_state_next;
      addr_reg <= addr_next;
      hrdata <= hrdata_next;
      hreadyout <= hreadyout_next;
      hresp <= 1'b0;
    end
  end

  // ********************************************************************
  // Control, mode and status registers.
  // ********************************************************************
  always_comb
  begin
    ctl_next = ctl_reg;
    if (wr_en && is_reg(addr_reg, IDX_CONTROL))
    begin
      ctl_next = wdata & CTL_WMASK;
    end
    for (int n = 0; n < NUM_CH; n++)
    begin
      mode_next[n] = mode_reg[n];
      if (wr_mode[n])
      begin
        mode_next[n] = wdata;
      end
      if (wr_low[n])
      begin
        mode_next[n][MODE_COMP] = 1'b0;
      end
      if (wr_high[n])
      begin
        mode_next[n][MODE_COMP] = 1'b1;
      end
    end
    // Ones written to the status register clear flags; a new event in the
    // same cycle still sets its flag.
    status_next = status_reg;
    if (wr_en && is_reg(addr_reg, IDX_STATUS))
    begin
      status_next = status_reg & ~wdata;
    end
    status_next[NUM_CH-1:0] = status_next[NUM_CH-1:0] | chan_event;
    if (wrap)
    begin
      status_next[STA_OVF] = 1'b1;
    end
    if (other_overflow)
    begin
      status_next[STA_OTHER_OVF] = 1'b1;
    end
    irq_next = |(status_reg[NUM_CH-1:0] & chan_ie)
      || (status_reg[STA_OVF] && ctl_reg[CTL_OVF_IE])
      || (status_reg[STA_OTHER_OVF] && other_overflow_irq_enable);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_reg <= CTL_RESET;
      status_reg <= STA_RESET;
      irq <= 1'b0;
      for (int n = 0; n < NUM_CH; n++)
      begin
        mode_reg[n] <= MODE_RESET;
      end
    end
    else if (ce)
    begin
      ctl_reg <= ctl_next;
      status_reg <= status_next;
      irq <= irq_next;
      for (int n = 0; n < NUM_CH; n++)
      begin
        mode_reg[n] <= mode_next[n];
      end
    end
  end

  // ********************************************************************
  // Array counter.
  // ********************************************************************
  // External pin edges are found at the system clock, which is why that
  // source must stay well below the clock rate.
  always_comb
  begin
    ext_prev_next = ext_clock;
    case (ctl_reg[1:0])
      CLK_PRESCALE: tick = prescaler_tick;
      CLK_TIMER0: tick = timer0_overflow;
      CLK_EXT: tick = ext_clock && !ext_prev_reg;
      default: tick = 1'b0;
    endcase
    run = ctl_reg[CTL_RUN] && !(ctl_reg[CTL_IDLE] && idle_mode);
    wrap_max = ctl_reg[CTL_TEN] ? CNT_MAX10 : CNT_MAX16;
    wrap = run && tick && (cnt_reg >= wrap_max);
    step_next = run && tick;
    cnt_next = cnt_reg;
    if (wrap)
    begin
      cnt_next = CNT_RESET;
    end
    else if (run && tick)
    begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= CNT_RESET;
      step_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      ext_prev_reg <= ext_prev_next;
    end
  end

  // ********************************************************************
  // Channels.
  // ********************************************************************
  for (genvar g = 0; g < NUM_CH; g++)
  begin : gen_ch
    assign wr_low[g] = wr_en && is_reg(addr_reg, IDX_CMPL0 + 10'(g));
    assign wr_high[g] = wr_en && is_reg(addr_reg, IDX_CMPH0 + 10'(g));
    assign wr_mode[g] = wr_en && is_reg(addr_reg, IDX_MODE0 + 10'(g));
    assign chan_ie[g] = mode_reg[g][MODE_IE];
    timer_channel u_ch (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .mode(mode_reg[g]),
      .ten_bit(ctl_reg[CTL_TEN]),
      .cnt(cnt_reg),
      .step(step_reg),
      .wr_low(wr_low[g]),
      .wr_high(wr_high[g]),
      .wdata(wdata),
      .pin_in(channel_pin_in[g]),
      .cmp(cmp[g]),
      .event_pulse(chan_event[g]),
      .pin_out(channel_pin_out[g]),
      .pin_oe_n(channel_pin_oe_n[g])
    );
    a_high_arms: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && wr_high[g] |=> mode_reg[g][MODE_COMP])
      else $error("compare high write did not arm the comparator");
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  a_run_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && ctl_reg[CTL_RUN] && !(wr_en && is_reg(addr_reg, IDX_CONTROL))
    |=> ctl_reg[CTL_RUN])
    else $error("run bit dropped without a software write");
  a_ovf_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && status_reg[STA_OVF] && ctl_reg[CTL_OVF_IE] |=> irq)
    else $error("enabled overflow did not request an interrupt");
  a_idle_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && idle_mode && ctl_reg[CTL_IDLE] |=> $stable(cnt_reg))
    else $error("counter moved in idle with idle stop set");
  a_ten_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && run && tick && ctl_reg[CTL_TEN] && cnt_reg == CNT_MAX10
    |=> cnt_reg == CNT_RESET)
    else $error("10-bit counter did not wrap at its maximum");
  a_timer0_src: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && ctl_reg[1:0] == CLK_TIMER0 && !timer0_overflow
    |=> $stable(cnt_reg))
    else $error("counter advanced without a timer 0 overflow");
  a_irq_merge: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (status_reg[NUM_CH-1:0] & chan_ie) != 6'h00 |=> irq)
    else $error("enabled channel flag did not request an interrupt");
  a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (status_reg[NUM_CH-1:0] & chan_ie) == 6'h00
    && !(status_reg[STA_OVF] && ctl_reg[CTL_OVF_IE])
    && !(status_reg[STA_OTHER_OVF] && other_overflow_irq_enable)
    |=> !irq)
    else $error("interrupt requested with every source gated off");
  a_wrap_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && run && tick && cnt_reg == wrap_max
    |=> status_reg[STA_OVF] && cnt_reg == CNT_RESET)
    else $error("counter wrap did not set the overflow flag");
endmodule

// file: verilog/timer_channel.sv
`timescale 1ns/1ps
module timer_channel (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Configuration and counter.
  input wire logic [7:0] mode,
  input wire logic ten_bit,
  input wire logic [15:0] cnt,
  input wire logic step,
  // Compare byte writes.
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  // Results.
  input wire logic pin_in,
  output logic [15:0] cmp,
  output logic event_pulse,
  output logic pin_out,
  output logic pin_oe_n
);
  import ca_pkg::*;

  logic [15:0] cmp_next;
  logic prev_reg, prev_next, out_next, oe_n_next;
  logic rise, fall, capture, match, ge;

  always_comb
  begin
    rise = pin_in && !prev_reg;
    fall = !pin_in && prev_reg;
    capture = (rise && mode[MODE_CAPR]) || (fall && mode[MODE_CAPF]);
    match = step && mode[MODE_COMP] && (cnt == cmp);
    if (mode[1:0] == PWM_WIDE)
    begin
      ge = ten_bit ? (cnt[9:0] >= cmp[9:0]) : (cnt >= cmp);
    end
    else
    begin
      ge = cnt[7:0] >= cmp[15:8];
    end
    cmp_next = cmp;
    if (wr_low)
    begin
      cmp_next[7:0] = wdata;
    end
    if (wr_high)
    begin
      cmp_next[15:8] = wdata;
    end
    // A capture beats a software write landing in the same cycle.
    if (capture)
    begin
      cmp_next = cnt;
    end
    prev_next = pin_in;
    out_next = pin_out;
    if (mode[1:0] != PWM_OFF)
    begin
      out_next = mode[MODE_COMP] && ge;
    end
    else if (mode[MODE_TOGGLE] && match)
    begin
      out_next = !pin_out;
    end
    oe_n_next = !((mode[1:0] != PWM_OFF) || mode[MODE_TOGGLE]);
    event_pulse = capture || (match && mode[MODE_MATCH]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp <= 16'h0000;
      prev_reg <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      cmp <= cmp_next;
      prev_reg <= prev_next;
      pin_out <= out_next;
      pin_oe_n <= oe_n_next;
    end
  end

  a_cap_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && rise && mode[MODE_CAPR] |=> cmp == $past(cnt))
    else $error("rising edge did not capture the counter");
  a_cap_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && fall && mode[MODE_CAPF] |=> cmp == $past(cnt))
    else $error("falling edge did not capture the counter");
  a_cap_both: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise || fall) && mode[5:4] == 2'b11 |-> event_pulse)
    else $error("transition capture missed an edge");
  a_match_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    step && cnt == cmp && mode[MODE_COMP] && mode[MODE_MATCH]
    |-> event_pulse)
    else $error("match did not raise the channel event");
  a_comp_off: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !mode[MODE_COMP] && mode[1:0] == PWM_OFF |=> $stable(pin_out))
    else $error("disabled comparator moved the pin");
  a_toggle_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && match && mode[MODE_TOGGLE] && mode[1:0] == PWM_OFF
    |=> pin_out != $past(pin_out))
    else $error("match did not toggle the pin");
  a_pwm_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode[1:0] != PWM_OFF |=> !pin_oe_n)
    else $error("pwm channel does not drive its pin");
endmodule
